// ### core/sram_port_regs.svh
// Timing and width constants for the static memory host port
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH
`define ADDR_W 19
`define DATA_W 8
`define CLK_PERIOD_NS 5
// Read cycle time and write pulse width, fastest grade, in ns
`define T_RC_NS 35
`define T_PWE_NS 25
`define T_SD_NS 20
`define T_HZWE_NS 10
`define T_LZWE_NS 3
`define T_HD_NS 0
`define T_SDR_NS 0
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W 8
// Extra read cycles that cover the three-flop input path
`define SYNC_LAT 3
`endif

// ### core/sram_port_pkg.sv
// Types for the static memory host port
package sram_port_pkg;
	typedef struct packed {
		logic write;
		logic [18:0] addr;
		logic [7:0] wdata;
	} req_t;
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_enable_n;
		logic [18:0] byte_address;
	} pins_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WSETUP = 3'h1,
		ST_WPULSE = 3'h3,
		ST_WHOLD = 3'h2,
		ST_READ = 3'h4,
		ST_RECOVER = 3'h5
	} state_t;
endpackage : sram_port_pkg

// ### core/pin_sync3.sv
// Three-stage synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;

	// Accept a change only once stages two and three agree, per bit
	always_comb
	begin
		for (int i = 0; i < W; i++)
			out_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : out_r[i];
	end

	// Stage one feeds stage two only
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			out_r <= '0;
		end
		else if (clk_en)
		begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign pin_out = out_r;
endmodule : pin_sync3
`default_nettype wire

// ### core/sram_host_port.sv
// Host controller driving an asynchronous 512K x 8 static memory
`timescale 1ns/10ps
`default_nettype none
`include "sram_port_regs.svh"

// Notes on behaviour
// - Host holds write enable high through every read cycle.
// - Held select and output enable: data follows each new address.
// - Host presents a valid address no later than select falling.
// - Write starts with both low; releasing either ends it.
// - Data setup and hold timed to write end; hold at least 0 ns.
// - Select high no later than 0 ns before supply falls for retention.
// - After retention wait one read cycle time before any access.
module sram_host_port #(
	parameter int RD_CYC = `CYC_UP(`T_RC_NS),
	parameter int WR_CYC = `CYC_UP(`T_PWE_NS)
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic req_valid,
	input wire sram_port_pkg::req_t req,
	output logic req_ready,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic wr_done,
	input wire logic retain_req,
	output logic retain_ack,
	output sram_port_pkg::pins_t pins,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe_n,
	input wire logic [7:0] data_bus_in
);
	localparam logic [`CNT_W-1:0] RD_CNT = RD_CYC[`CNT_W-1:0];
	localparam logic [`CNT_W-1:0] WR_CNT = WR_CYC[`CNT_W-1:0];
	// Float wait counted from select falling; host drives the bus one cycle after write enable falls
	localparam logic [`CNT_W-1:0] HZ_CNT = `CNT_W'(`CYC_UP(`T_HZWE_NS));
	localparam logic [`CNT_W-1:0] ONE = `CNT_W'(1);

	sram_port_pkg::state_t st_r, st_nxt;
	sram_port_pkg::pins_t pins_r, pins_nxt;
	logic [`CNT_W-1:0] cnt_r, cnt_nxt;
	logic [7:0] wdat_r, wdat_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic oe_n_r, oe_n_nxt;
	logic rv_r, rv_nxt;
	logic wd_r, wd_nxt;
	logic rdy_r, rdy_nxt;
	logic ret_r, ret_nxt;
	logic [7:0] din_sync;

	// Read data crosses in from the pins, so it is synchronised
	pin_sync3 #(
		.W(8)
	) u_din_sync (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.pin_in(data_bus_in),
		.pin_out(din_sync)
	);

	// Sequencer: one access at a time, strobes come from flops only
	always_comb
	begin
		st_nxt = st_r;
		pins_nxt = pins_r;
		cnt_nxt = cnt_r;
		wdat_nxt = wdat_r;
		rdata_nxt = rdata_r;
		oe_n_nxt = oe_n_r;
		rv_nxt = 1'b0;
		wd_nxt = 1'b0;
		rdy_nxt = rdy_r;
		ret_nxt = ret_r;
		case (st_r)
			sram_port_pkg::ST_IDLE:
			begin
				pins_nxt.chip_select_n = 1'b1;
				pins_nxt.output_enable_n = 1'b1;
				pins_nxt.write_enable_n = 1'b1;
				oe_n_nxt = 1'b1;
				if (retain_req)
				begin
					ret_nxt = 1'b1;
					rdy_nxt = 1'b0;
				end
				else if (ret_r)
				begin
					// Leaving retention costs one read cycle time
					ret_nxt = 1'b0;
					cnt_nxt = RD_CNT;
					st_nxt = sram_port_pkg::ST_RECOVER;
				end
				else if (req_valid && rdy_r)
				begin
					rdy_nxt = 1'b0;
					pins_nxt.byte_address = req.addr;
					wdat_nxt = req.wdata;
					pins_nxt.chip_select_n = 1'b0;
					if (req.write)
					begin
						// Address settles before write enable falls
						cnt_nxt = HZ_CNT;
						st_nxt = sram_port_pkg::ST_WSETUP;
					end
					else
					begin
						pins_nxt.output_enable_n = 1'b0;
						pins_nxt.write_enable_n = 1'b1;
						// Extra cycles cover the three-flop input path
						cnt_nxt = RD_CNT + `CNT_W'(`SYNC_LAT);
						st_nxt = sram_port_pkg::ST_READ;
					end
				end
			end
			sram_port_pkg::ST_READ:
			begin
				if (cnt_r > ONE)
					cnt_nxt = cnt_r - ONE;
				else
				begin
					rdata_nxt = din_sync;
					rv_nxt = 1'b1;
					pins_nxt.chip_select_n = 1'b1;
					pins_nxt.output_enable_n = 1'b1;
					rdy_nxt = 1'b1;
					st_nxt = sram_port_pkg::ST_IDLE;
				end
			end
			sram_port_pkg::ST_WSETUP:
			begin
				// Output enable stays high, so the memory never drives
				pins_nxt.write_enable_n = 1'b0;
				if (cnt_r > ONE)
					cnt_nxt = cnt_r - ONE;
				else
				begin
					oe_n_nxt = 1'b0;
					cnt_nxt = WR_CNT;
					st_nxt = sram_port_pkg::ST_WPULSE;
				end
			end
			sram_port_pkg::ST_WPULSE:
			begin
				// Pulse covers data setup before the ending edge
				if (cnt_r > ONE)
					cnt_nxt = cnt_r - ONE;
				else
				begin
					pins_nxt.write_enable_n = 1'b1;
					st_nxt = sram_port_pkg::ST_WHOLD;
				end
			end
			sram_port_pkg::ST_WHOLD:
			begin
				// Data held one cycle past write end, then released
				oe_n_nxt = 1'b1;
				pins_nxt.chip_select_n = 1'b1;
				wd_nxt = 1'b1;
				rdy_nxt = 1'b1;
				st_nxt = sram_port_pkg::ST_IDLE;
			end
			sram_port_pkg::ST_RECOVER:
			begin
				if (cnt_r > ONE)
					cnt_nxt = cnt_r - ONE;
				else
				begin
					rdy_nxt = 1'b1;
					st_nxt = sram_port_pkg::ST_IDLE;
				end
			end
			default:
			begin
				st_nxt = sram_port_pkg::ST_IDLE;
				rdy_nxt = 1'b1;
			end
		endcase
	end

	// Registers; all outputs leave from here
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_r <= sram_port_pkg::ST_IDLE;
			pins_r <= '{chip_select_n: 1'b1, output_enable_n: 1'b1,
				write_enable_n: 1'b1, byte_address: '0};
			cnt_r <= '0;
			wdat_r <= '0;
			rdata_r <= '0;
			oe_n_r <= 1'b1;
			rv_r <= 1'b0;
			wd_r <= 1'b0;
			rdy_r <= 1'b1;
			ret_r <= 1'b0;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
			pins_r <= pins_nxt;
			cnt_r <= cnt_nxt;
			wdat_r <= wdat_nxt;
			rdata_r <= rdata_nxt;
			oe_n_r <= oe_n_nxt;
			rv_r <= rv_nxt;
			wd_r <= wd_nxt;
			rdy_r <= rdy_nxt;
			ret_r <= ret_nxt;
		end
	end

	assign pins = pins_r;
	assign data_bus_out = wdat_r;
	assign data_bus_oe_n = oe_n_r;
	assign rdata = rdata_r;
	assign rdata_valid = rv_r;
	assign wr_done = wd_r;
	assign req_ready = rdy_r;
	assign retain_ack = ret_r;
endmodule : sram_host_port
`default_nettype wire

// ### tb/sram_device_model.sv
// Behavioural static memory on the far side of the host port
`timescale 1ns/10ps
`default_nettype none
module sram_device_model (
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [18:0] byte_address,
	input wire logic [7:0] host_data,
	input wire logic host_oe_n,
	output logic [7:0] data_bus
);
	logic [7:0] mem [0:524287];
	logic [7:0] last;
	logic drive;
	// Drive only in a selected read; write enable low floats at once
	assign drive = !chip_select_n && !output_enable_n && write_enable_n;
	// Store the bus level while select and write enable overlap low
	always @*
		if (!chip_select_n && !write_enable_n)
			mem[byte_address] = data_bus;
	// Remember the last driven value
	always @*
		if (!host_oe_n)
			last = host_data;
		else if (drive)
			last = mem[byte_address];
	// A floating bus shows the inverse, so stale data never matches
	assign data_bus = !host_oe_n ? host_data : drive ? mem[byte_address] : ~last;
endmodule : sram_device_model
`default_nettype wire

// ### tb/sram_host_port_monitor.sv
// Protocol checker for the static memory host port
`timescale 1ns/10ps
`default_nettype none
module sram_host_port_monitor (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic req_valid,
	input wire sram_port_pkg::req_t req,
	input wire logic req_ready,
	input wire logic rdata_valid,
	input wire logic wr_done,
	input wire logic retain_req,
	input wire logic retain_ack,
	input wire sram_port_pkg::pins_t pins,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe_n
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// A request accepted by the port
	sequence take_s;
		clk_en && req_valid && req_ready && !retain_req && !retain_ack;
	endsequence
	a_read_we_high: assert property (!pins.output_enable_n |-> pins.write_enable_n)
		else $error("write enable low in read");
	a_addr_held: assert property (!pins.chip_select_n && !$past(pins.chip_select_n)
		|-> $stable(pins.byte_address)) else $error("address moved");
	a_we_needs_cs: assert property (!pins.write_enable_n |-> !pins.chip_select_n)
		else $error("write without select");
	a_data_hold: assert property ($rose(pins.write_enable_n)
		|-> !data_bus_oe_n && $stable(data_bus_out)) else $error("no data hold");
	a_retain_desel: assert property (retain_ack |-> pins.chip_select_n)
		else $error("selected in retention");
	a_recover_wait: assert property ($fell(retain_ack) |-> pins.chip_select_n[*7])
		else $error("early access");
	a_read_time: assert property (take_s ##0 !req.write |-> ##11 rdata_valid)
		else $error("read late");
	a_write_time: assert property (take_s ##0 req.write |-> ##9 wr_done)
		else $error("write late");
endmodule : sram_host_port_monitor
bind sram_host_port sram_host_port_monitor mon (
	.mclk(mclk),
	.rstn(rstn),
	.clk_en(clk_en),
	.req_valid(req_valid),
	.req(req),
	.req_ready(req_ready),
	.rdata_valid(rdata_valid),
	.wr_done(wr_done),
	.retain_req(retain_req),
	.retain_ack(retain_ack),
	.pins(pins),
	.data_bus_out(data_bus_out),
	.data_bus_oe_n(data_bus_oe_n)
);
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the static memory host port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic req_valid = 1'b0;
	logic retain_req = 1'b0;
	sram_port_pkg::req_t req = '0;
	sram_port_pkg::pins_t pins;
	logic req_ready, rdata_valid, wr_done, retain_ack, data_bus_oe_n;
	logic [7:0] rdata, data_bus_out, data_bus_in;
	int miscompares = 0;
	int check_count = 0;
	// Clock of 5 ns
	always #2.5 mclk = ~mclk;
	sram_host_port dut (
		.mclk(mclk),
		.rstn(rstn),
		.clk_en(clk_en),
		.req_valid(req_valid),
		.req(req),
		.req_ready(req_ready),
		.rdata(rdata),
		.rdata_valid(rdata_valid),
		.wr_done(wr_done),
		.retain_req(retain_req),
		.retain_ack(retain_ack),
		.pins(pins),
		.data_bus_out(data_bus_out),
		.data_bus_oe_n(data_bus_oe_n),
		.data_bus_in(data_bus_in)
	);
	sram_device_model mem (.chip_select_n(pins.chip_select_n),
		.output_enable_n(pins.output_enable_n),
		.write_enable_n(pins.write_enable_n), .byte_address(pins.byte_address),
		.host_data(data_bus_out), .host_oe_n(data_bus_oe_n),
		.data_bus(data_bus_in));
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Bounded wait at falling edges, where outputs have settled
	task automatic wait_hi(ref logic s, output int n);
		n = 0;
		while (s !== 1'b1)
		begin
			@(negedge mclk);
			n++;
			if (n > 40)
			begin
				miscompares++;
				test_done();
			end
		end
	endtask : wait_hi
	// One request, held until taken, then wait for its end pulse
	task automatic xfer(input logic w, input logic [18:0] a, input logic [7:0] d);
		int n;
		wait_hi(req_ready, n);
		req = '{w, a, d};
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		if (w)
			wait_hi(wr_done, n);
		else
			wait_hi(rdata_valid, n);
	endtask : xfer
	// Address extremes and one mid address, written then read back
	task automatic t_boundary;
		logic [18:0] a [3] = '{19'h00000, 19'h7ffff, 19'h2a5c3};
		logic [7:0] d [3] = '{8'ha5, 8'h5a, 8'h3c};
		for (int i = 0; i < 3; i++)
			xfer(1'b1, a[i], d[i]);
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b0, a[i], 8'h00);
			chk(rdata, d[i]);
		end
	endtask : t_boundary
	// Back-to-back writes to one place; last one wins
	task automatic t_overwrite;
		xfer(1'b1, 19'h00010, 8'h11);
		xfer(1'b1, 19'h00010, 8'h22);
		xfer(1'b0, 19'h00010, 8'h00);
		chk(rdata, 8'h22);
		chk({5'h00, pins.chip_select_n, pins.write_enable_n, data_bus_oe_n}, 8'h07);
	endtask : t_overwrite
	// Retention hold, recovery wait, contents kept
	task automatic t_retention;
		int n;
		retain_req = 1'b1;
		wait_hi(retain_ack, n);
		repeat (20) @(negedge mclk);
		chk({7'h00, pins.chip_select_n}, 8'h01);
		// Frozen clock enable must keep the hold after the request drops
		clk_en = 1'b0;
		retain_req = 1'b0;
		repeat (4) @(negedge mclk);
		chk({7'h00, retain_ack}, 8'h01);
		clk_en = 1'b1;
		wait_hi(req_ready, n);
		chk({7'h00, n >= 7}, 8'h01);
		xfer(1'b0, 19'h7ffff, 8'h00);
		chk(rdata, 8'h5a);
	endtask : t_retention
	initial
	begin
		repeat (8) @(negedge mclk);
		rstn = 1'b1;
		t_boundary();
		t_overwrite();
		t_retention();
		test_done();
	end
endmodule : tb_top
`default_nettype wire
